// ### bench/ssp_sram_properties.sv
`timescale 1ns/1ps
module ssp_sram_properties
  import ssp_pkg::*;
#(
  parameter int LANES = SSP_LANES,
  parameter int LANE_W = SSP_LANE_W
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic chip_select_low_first,
  input wire logic chip_select_high_second,
  input wire logic chip_select_third_n,
  input wire logic addr_step_load,
  input wire logic rd_wr_sel,
  input wire logic [LANES-1:0] byte_lane_strobe_n,
  input wire logic clk_en_n,
  input wire logic out_en_n,
  input wire logic sleep_request,
  input wire logic ctl_dq_oe,
  input wire logic [LANES*LANE_W-1:0] dev_dq_out,
  input wire logic dev_dq_oe
);
  // ****
  // decoded command at each edge
  // ****
  wire sel = !chip_select_low_first && chip_select_high_second && !chip_select_third_n;
  wire ld = !clk_en_n && !addr_step_load;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  // two low samples before the command: device surely awake when the command lands
  property p_rd_drive;
    (!sleep_request)[*2] ##1 (ld && sel && rd_wr_sel) |=> dev_dq_oe;
  endproperty
  a_rd_drive: assert property (p_rd_drive) else $error("read data not driven");
  property p_wdata;
    ld && sel && !rd_wr_sel && (byte_lane_strobe_n != '1) |=> ctl_dq_oe;
  endproperty
  a_wdata: assert property (p_wdata) else $error("write data late");
  property p_freeze;
    (!sleep_request)[*3] ##0 clk_en_n |=> $stable({dev_dq_oe, dev_dq_out});
  endproperty
  a_freeze: assert property (p_freeze) else $error("ignored edge changed output");
  property p_desel;
    (!sleep_request)[*2] ##1 (ld && !sel) |=> !dev_dq_oe;
  endproperty
  a_desel: assert property (p_desel) else $error("deselect still drives");
  property p_cdesel;
    (!sleep_request)[*2] ##1 (ld && !sel) ##1 (!clk_en_n && addr_step_load) |=> !dev_dq_oe;
  endproperty
  a_cdesel: assert property (p_cdesel) else $error("continue deselect drives");
  property p_sleep_hiz;
    sleep_request[*3] |-> !dev_dq_oe;
  endproperty
  a_sleep_hiz: assert property (p_sleep_hiz) else $error("asleep but driving");
  property p_oe_gate;
    dev_dq_oe |-> !out_en_n;
  endproperty
  a_oe_gate: assert property (p_oe_gate) else $error("drive without enable");
  property p_no_clash;
    !(dev_dq_oe && ctl_dq_oe);
  endproperty
  a_no_clash: assert property (p_no_clash) else $error("both ends drive");
  c_read: cover property (ld && sel && rd_wr_sel);
  c_write: cover property (ld && sel && !rd_wr_sel);
  c_sleep: cover property (sleep_request[*3]);
  c_hold: cover property (clk_en_n[*2]);
endmodule

// ### bench/sync_flowthrough_sram_port_tb.sv
`timescale 1ns/1ps
module sync_flowthrough_sram_port_tb
  import ssp_pkg::*;
;
  localparam int AW = 8;
  logic clk, nrst, cmd_valid, cmd_ready, suspend, sleep_in, order_in;
  logic rd_valid, sleeping, deselected;
  ssp_op_e cmd_op;
  logic [AW-1:0] cmd_addr;
  logic [3:0] cmd_strb_n;
  logic [35:0] cmd_wdata, rd_data;
  logic [35:0] eq[$];
  int bad_count = 0;
  int total_checks = 0;

  ssp_if #(.ADDR_W(AW)) ssp_if_inst ();
  ssp_sram_dev #(.ADDR_W(AW)) ssp_sram_dev_inst (.clk(clk), .nrst(nrst), .bus(ssp_if_inst),
    .sleeping(sleeping), .deselected(deselected));
  ssp_sram_ctl #(.ADDR_W(AW)) ssp_sram_ctl_inst (.clk(clk), .nrst(nrst), .bus(ssp_if_inst),
    .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_strb_n(cmd_strb_n),
    .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .suspend(suspend), .sleep_in(sleep_in),
    .order_in(order_in), .rd_data(rd_data), .rd_valid(rd_valid));
  ssp_sram_properties chk_inst (.clk(clk), .nrst(nrst),
    .chip_select_low_first(ssp_if_inst.chip_select_low_first),
    .chip_select_high_second(ssp_if_inst.chip_select_high_second),
    .chip_select_third_n(ssp_if_inst.chip_select_third_n),
    .addr_step_load(ssp_if_inst.addr_step_load), .rd_wr_sel(ssp_if_inst.rd_wr_sel),
    .byte_lane_strobe_n(ssp_if_inst.byte_lane_strobe_n), .clk_en_n(ssp_if_inst.clk_en_n),
    .out_en_n(ssp_if_inst.out_en_n), .sleep_request(ssp_if_inst.sleep_request),
    .ctl_dq_oe(ssp_if_inst.ctl_dq_oe), .dev_dq_out(ssp_if_inst.dev_dq_out),
    .dev_dq_oe(ssp_if_inst.dev_dq_oe));

  // ****
  // helpers
  // ****
  task report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic fail(string m);
    bad_count++;
    $display("Error %0t: %s", $time, m);
  endtask
  task automatic chk(logic [35:0] g, logic [35:0] e);
    total_checks++;
    if (g !== e) begin
      fail($sformatf("got %h expected %h", g, e));
    end
  endtask
  function automatic logic [35:0] pat(int i);
    pat = {4{9'(i)}};
  endfunction
  // valid is left high so back-to-back beats need no gap
  task automatic issue(ssp_op_e op, logic [AW-1:0] a, logic [3:0] s, logic [35:0] d);
    int n;
    logic hit;
    n = 0;
    hit = 1'b0;
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_addr <= a;
    cmd_strb_n <= s;
    cmd_wdata <= d;
    // sampled before the edge's own updates land, as the design sees them
    do begin
      @(posedge clk);
      hit = (cmd_valid === 1'b1) && (cmd_ready === 1'b1);
      n++;
    end while (!hit && n < 40);
    if (!hit) begin
      fail("command not taken");
    end
  endtask
  task automatic idle(int k);
    cmd_valid <= 1'b0;
    repeat (k) @(posedge clk);
  endtask
  task automatic rd(logic [AW-1:0] a, logic [35:0] e);
    eq.push_back(e);
    issue(SSP_OP_READ, a, 4'hf, '0);
  endtask

  always @(posedge clk) begin
    if (rd_valid === 1'b1) begin
      if (eq.size() == 0) begin
        fail("unexpected read data");
      end else begin
        chk(rd_data, eq.pop_front());
      end
    end
  end

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    repeat (3000) @(posedge clk);
    fail("timeout");
    report_and_stop();
  end

  // ****
  // main sequence
  // ****
  initial begin
    int n;
    {nrst, cmd_valid, suspend, sleep_in, order_in} = '0;
    cmd_op = SSP_OP_DESEL;
    cmd_addr = '0;
    cmd_strb_n = 4'hf;
    cmd_wdata = '0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    issue(SSP_OP_WRITE, 8'h10, 4'h0, 36'h1_2345_6789);
    issue(SSP_OP_WRITE, 8'h11, 4'h0, 36'h0_0000_0000);
    issue(SSP_OP_WRITE, 8'h11, 4'ha, 36'hf_ffff_ffff);
    issue(SSP_OP_WRITE, 8'h10, 4'hf, 36'h0_0000_0000);
    rd(8'h10, 36'h1_2345_6789);
    rd(8'h11, 36'h0_07fc_01ff);
    $display("lane write test done");
    issue(SSP_OP_WRITE, 8'h30, 4'h0, pat(9));
    for (int k = 0; k < 4; k++) begin
      issue(k ? SSP_OP_BURST : SSP_OP_WRITE, 8'h32, k == 2 ? 4'hf : 4'h0, pat(5 + k));
    end
    for (int j = 0; j < 4; j++) begin
      rd(8'h30 + 8'(j), pat(j == 0 ? 9 : (j == 1 ? 8 : j + 3)));
    end
    $display("burst write test done");
    for (int i = 0; i < 4; i++) begin
      issue(SSP_OP_WRITE, 8'h20 + 8'(i), 4'h0, pat(i));
    end
    for (int o = 0; o < 2; o++) begin
      idle(2);
      order_in <= o[0];
      idle(2);
      for (int k = 0; k < 4; k++) begin
        eq.push_back(pat(o ? (1 ^ k) : ((1 + k) & 3)));
        issue(k ? SSP_OP_BURST : SSP_OP_READ, 8'h21, 4'hf, '0);
      end
    end
    $display("burst order test done");
    rd(8'h10, 36'h1_2345_6789);
    suspend <= 1'b1;
    idle(4);
    suspend <= 1'b0;
    issue(SSP_OP_DESEL, 8'h00, 4'hf, '0);
    issue(SSP_OP_BURST, 8'h00, 4'hf, '0);
    idle(2);
    chk(36'(deselected), 36'h0_0000_0001);
    $display("suspend and deselect test done");
    sleep_in <= 1'b1;
    idle(5);
    chk(36'(sleeping), 36'h0_0000_0001);
    sleep_in <= 1'b0;
    idle(5);
    chk(36'(sleeping), 36'h0_0000_0000);
    rd(8'h11, 36'h0_07fc_01ff);
    idle(1);
    n = 0;
    while (eq.size() != 0 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (eq.size() != 0) begin
      fail("read data missing");
    end
    $display("sleep test done");
    report_and_stop();
  end
endmodule

// ### common/ssp_if.sv
`timescale 1ns/1ps
interface ssp_if
  import ssp_pkg::*;
#(
  parameter int ADDR_W = SSP_ADDR_W,
  parameter int LANES = SSP_LANES,
  parameter int LANE_W = SSP_LANE_W
);
  logic chip_select_low_first;
  logic chip_select_high_second;
  logic chip_select_third_n;
  logic [ADDR_W-1:0] addr;
  logic addr_step_load;
  logic rd_wr_sel;
  logic [LANES-1:0] byte_lane_strobe_n;
  logic clk_en_n;
  logic out_en_n;
  logic sleep_request;
  logic burst_order_select;
  logic [LANES*LANE_W-1:0] ctl_dq_out;
  logic ctl_dq_oe;
  logic [LANES*LANE_W-1:0] dev_dq_out;
  logic dev_dq_oe;
  logic [LANES*LANE_W-1:0] dq;

  // undriven bus reads as zero; device drive wins on contention
  assign dq = dev_dq_oe ? dev_dq_out : (ctl_dq_oe ? ctl_dq_out : '0);

  modport dev (
    input chip_select_low_first,
    input chip_select_high_second,
    input chip_select_third_n,
    input addr,
    input addr_step_load,
    input rd_wr_sel,
    input byte_lane_strobe_n,
    input clk_en_n,
    input out_en_n,
    input sleep_request,
    input burst_order_select,
    input dq,
    output dev_dq_out,
    output dev_dq_oe
  );

  modport ctl (
    output chip_select_low_first,
    output chip_select_high_second,
    output chip_select_third_n,
    output addr,
    output addr_step_load,
    output rd_wr_sel,
    output byte_lane_strobe_n,
    output clk_en_n,
    output out_en_n,
    output sleep_request,
    output burst_order_select,
    output ctl_dq_out,
    output ctl_dq_oe,
    input dq
  );
endinterface

// ### common/ssp_pkg.sv
// Contract
// RQ1 - state changes only on rising clock edges
// RQ2 - selected, load, read high: begin burst read
// RQ3 - advance during read burst reads next address
// RQ4 - selected, load, write low: begin burst write
// RQ5 - advance in write burst; all strobes high aborts
// RQ6 - continue-deselect only after a deselect cycle
// RQ7 - sleep and output drive qualify every command
// RQ8 - controller holds read/write and strobes stable
// RQ9 - write only lanes whose strobes are low
// RQ10 - clock enable high freezes address and state
// RQ11 - write data follows command by one cycle
// RQ12 - linear or interleaved four-beat burst order
// RQ13 - sleep entry and wake take two cycles
package ssp_pkg;

  // ****************************************
  // geometry
  // ****************************************
  localparam int SSP_ADDR_W = 19;
  localparam int SSP_LANES = 4;
  localparam int SSP_LANE_W = 9;
  localparam int SSP_BURST_W = 2;

  // ****************************************
  // timing, in clock cycles
  // ****************************************
  localparam int SSP_SLEEP_ENTER_CYC = 2;
  localparam int SSP_SLEEP_EXIT_CYC = 2;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    SSP_DESEL = 2'b00,
    SSP_READ = 2'b01,
    SSP_WRITE = 2'b10
  } ssp_state_e;

  typedef enum logic [1:0] {
    SSP_OP_DESEL = 2'b00,
    SSP_OP_READ = 2'b01,
    SSP_OP_WRITE = 2'b10,
    SSP_OP_BURST = 2'b11
  } ssp_op_e;

  // low burst bits for beat 'step' from start 'lo'
  function automatic logic [SSP_BURST_W-1:0] ssp_burst_lo(
    input logic [SSP_BURST_W-1:0] lo,
    input logic [SSP_BURST_W-1:0] step,
    input logic interleave
  );
    ssp_burst_lo = interleave ? (lo ^ step) : SSP_BURST_W'(lo + step); // [RQ12]
  endfunction

endpackage

// ### rtl/ssp_sram_ctl.sv
`timescale 1ns/1ps
module ssp_sram_ctl
  import ssp_pkg::*;
#(
  parameter int ADDR_W = SSP_ADDR_W,
  parameter int LANES = SSP_LANES,
  parameter int LANE_W = SSP_LANE_W
) (
  input wire logic clk,
  input wire logic nrst,
  ssp_if.ctl bus,
  input wire logic cmd_valid,
  input wire ssp_op_e cmd_op,
  input wire logic [ADDR_W-1:0] cmd_addr,
  input wire logic [LANES-1:0] cmd_strb_n,
  input wire logic [LANES*LANE_W-1:0] cmd_wdata,
  output logic cmd_ready,
  input wire logic suspend,
  input wire logic sleep_in,
  input wire logic order_in,
  output logic [LANES*LANE_W-1:0] rd_data,
  output logic rd_valid
);

  localparam int DW = LANES * LANE_W;
  localparam int WCW = 2;

  // ****************************************
  // pin registers
  // ****************************************
  logic started_r;
  ssp_state_e kind_r;
  logic cs_n_r;
  logic step_r;
  logic rw_r;
  logic [ADDR_W-1:0] addr_r;
  logic [LANES-1:0] strb_n_r;
  logic cke_n_r;
  logic zz_r;
  logic order_r;
  logic wd_p1_v_r;
  logic [DW-1:0] wd_p1_r;
  logic wd_oe_r;
  logic [DW-1:0] wd_out_r;
  logic rd_p1_r;
  logic rd_p2_r;
  logic [DW-1:0] rd_data_r;
  logic rd_valid_r;
  logic take;
  logic dev_edge;
  logic burst_ok;
  logic [WCW-1:0] wake_cnt_r;

  // a burst is only legal once the first deselect has gone out
  assign burst_ok = (cmd_op != SSP_OP_BURST) || started_r; // [RQ6]
  assign cmd_ready = started_r && !suspend && !sleep_in && !zz_r
    && (wake_cnt_r == WCW'(SSP_SLEEP_EXIT_CYC - 1)); // [RQ13]
  assign take = cmd_valid && cmd_ready && burst_ok;
  // edge at which the device acts on what we drove
  assign dev_edge = !cke_n_r;

  // all pins from flops: stable across each edge
  always_ff @(posedge clk or negedge nrst) begin // [RQ8]
    if (!nrst) begin
      started_r <= 1'b0;
      kind_r <= SSP_DESEL;
      cs_n_r <= 1'b1;
      step_r <= 1'b0;
      rw_r <= 1'b1;
      addr_r <= '0;
      strb_n_r <= '1;
      cke_n_r <= 1'b0;
      zz_r <= 1'b0;
      order_r <= 1'b0;
    end else begin
      cke_n_r <= suspend;
      zz_r <= sleep_in;
      order_r <= order_in;
      if (!suspend) begin
        started_r <= 1'b1;
        strb_n_r <= '1;
        if (take && (cmd_op == SSP_OP_BURST)) begin
          step_r <= 1'b1;
          strb_n_r <= cmd_strb_n; // [RQ5]
        end else if (take && (cmd_op != SSP_OP_DESEL)) begin
          step_r <= 1'b0;
          cs_n_r <= 1'b0;
          addr_r <= cmd_addr;
          rw_r <= (cmd_op == SSP_OP_READ); // [RQ2] [RQ4]
          strb_n_r <= cmd_strb_n;
          kind_r <= (cmd_op == SSP_OP_READ) ? SSP_READ : SSP_WRITE;
        end else begin
          // idle or explicit deselect, also the first cycle
          step_r <= 1'b0;
          cs_n_r <= 1'b1;
          kind_r <= SSP_DESEL; // [RQ6]
        end
      end
    end
  end

  assign bus.chip_select_low_first = cs_n_r;
  assign bus.chip_select_high_second = !cs_n_r;
  assign bus.chip_select_third_n = cs_n_r;
  assign bus.addr = addr_r;
  assign bus.addr_step_load = step_r;
  assign bus.rd_wr_sel = rw_r;
  assign bus.byte_lane_strobe_n = strb_n_r;
  assign bus.clk_en_n = cke_n_r;
  // output drive only while read data is expected, keeps the bus quiet otherwise
  assign bus.out_en_n = !rd_p2_r; // [RQ7]
  assign bus.sleep_request = zz_r;
  assign bus.burst_order_select = order_r;

  // ****************************************
  // write data, one device edge late
  // ****************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wd_p1_v_r <= 1'b0;
      wd_p1_r <= '0;
      wd_oe_r <= 1'b0;
      wd_out_r <= '0;
    end else begin
      if (!suspend) begin
        wd_p1_v_r <= take && ((cmd_op == SSP_OP_WRITE) ||
          (cmd_op == SSP_OP_BURST && kind_r == SSP_WRITE));
        wd_p1_r <= cmd_wdata;
      end
      if (dev_edge) begin
        wd_oe_r <= wd_p1_v_r; // [RQ11]
        wd_out_r <= wd_p1_r;
      end
    end
  end

  assign bus.ctl_dq_oe = wd_oe_r;
  assign bus.ctl_dq_out = wd_out_r;

  // ****************************************
  // read return
  // ****************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_p1_r <= 1'b0;
      rd_p2_r <= 1'b0;
      rd_data_r <= '0;
      rd_valid_r <= 1'b0;
    end else begin
      if (!suspend) begin
        rd_p1_r <= take && ((cmd_op == SSP_OP_READ) ||
          (cmd_op == SSP_OP_BURST && kind_r == SSP_READ));
      end
      if (dev_edge) begin
        rd_p2_r <= rd_p1_r;
      end
      rd_valid_r <= rd_p2_r && dev_edge;
      if (rd_p2_r && dev_edge) begin
        rd_data_r <= bus.dq;
      end
    end
  end

  // ****************************************
  // wake-up guard
  // ****************************************
  // commands sent before the device has seen enough low sleep samples are lost
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wake_cnt_r <= WCW'(SSP_SLEEP_EXIT_CYC - 1);
    end else if (zz_r) begin
      wake_cnt_r <= '0;
    end else if (wake_cnt_r != WCW'(SSP_SLEEP_EXIT_CYC - 1)) begin
      wake_cnt_r <= WCW'(wake_cnt_r + 1'b1); // [RQ13]
    end
  end

  assign rd_data = rd_data_r;
  assign rd_valid = rd_valid_r;

endmodule

// ### rtl/ssp_sram_dev.sv
`timescale 1ns/1ps
module ssp_sram_dev
  import ssp_pkg::*;
#(
  parameter int ADDR_W = SSP_ADDR_W,
  parameter int LANES = SSP_LANES,
  parameter int LANE_W = SSP_LANE_W
) (
  input wire logic clk,
  input wire logic nrst,
  ssp_if.dev bus,
  output logic sleeping,
  output logic deselected
);

  localparam int DW = LANES * LANE_W;
  localparam int CW = 2;

  // ****************************************
  // storage and control state
  // ****************************************
  logic [DW-1:0] mem [0:(1<<ADDR_W)-1];
  ssp_state_e state_r;
  logic [ADDR_W-1:0] base_r;
  logic [SSP_BURST_W-1:0] cnt_r;
  logic [DW-1:0] rd_data_r;
  logic rd_on_r;
  logic wr_pend_r;
  logic [ADDR_W-1:0] wr_addr_r;
  logic [LANES-1:0] wr_strb_n_r;
  logic asleep_r;
  logic [CW-1:0] zz_cnt_r;

  // ****************************************
  // command decode
  // ****************************************
  logic live;
  logic selected;
  logic load;
  logic begin_rd;
  logic begin_wr;
  logic cont_rd;
  logic cont_wr;
  logic any_lane;
  logic [SSP_BURST_W-1:0] step_nxt;
  logic [ADDR_W-1:0] acc_addr;
  logic [DW-1:0] rd_word;

  // asleep or suspended edges change nothing
  assign live = !bus.clk_en_n && !asleep_r; // [RQ10] [RQ13]
  assign selected = !bus.chip_select_low_first && bus.chip_select_high_second
    && !bus.chip_select_third_n;
  assign load = !bus.addr_step_load;
  assign any_lane = !(&bus.byte_lane_strobe_n);
  assign begin_rd = load && selected && bus.rd_wr_sel; // [RQ2]
  assign begin_wr = load && selected && !bus.rd_wr_sel; // [RQ4]
  // chip selects are not looked at while advancing
  assign cont_rd = !load && (state_r == SSP_READ); // [RQ3]
  assign cont_wr = !load && (state_r == SSP_WRITE); // [RQ5]
  assign step_nxt = SSP_BURST_W'(cnt_r + 1'b1);
  assign acc_addr = load ? bus.addr
    : {base_r[ADDR_W-1:SSP_BURST_W],
       ssp_burst_lo(base_r[SSP_BURST_W-1:0], step_nxt, bus.burst_order_select)}; // [RQ12]

  // merge a late write landing on the same edge so a read sees it
  always_comb begin
    rd_word = mem[acc_addr];
    if (wr_pend_r && (wr_addr_r == acc_addr)) begin
      for (int i = 0; i < LANES; i++) begin
        if (!wr_strb_n_r[i]) begin
          rd_word[i*LANE_W +: LANE_W] = bus.dq[i*LANE_W +: LANE_W];
        end
      end
    end
  end

  // ****************************************
  // burst state
  // ****************************************
  always_ff @(posedge clk or negedge nrst) begin // [RQ1]
    if (!nrst) begin
      state_r <= SSP_DESEL;
      base_r <= '0;
      cnt_r <= '0;
    end else if (live) begin
      if (load) begin
        base_r <= bus.addr;
        cnt_r <= '0;
        if (!selected) begin
          state_r <= SSP_DESEL;
        end else if (bus.rd_wr_sel) begin
          state_r <= SSP_READ;
        end else begin
          state_r <= SSP_WRITE;
        end
      end else if (state_r != SSP_DESEL) begin
        cnt_r <= step_nxt; // [RQ3] [RQ5]
      end
      // advancing while deselected keeps the part deselected
    end
  end

  // ****************************************
  // read path, flow-through
  // ****************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_data_r <= '0;
      rd_on_r <= 1'b0;
    end else if (live) begin
      rd_on_r <= begin_rd || cont_rd; // [RQ2] [RQ3]
      if (begin_rd || cont_rd) begin
        rd_data_r <= rd_word;
      end
    end
  end

  // drive only for a read, output drive low, not asleep
  assign bus.dev_dq_oe = rd_on_r && !bus.out_en_n && !asleep_r; // [RQ7]
  assign bus.dev_dq_out = rd_data_r;

  // ****************************************
  // late write
  // ****************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= '0;
      wr_strb_n_r <= '1;
    end else if (live) begin
      // all strobes high still advances but writes nothing
      wr_pend_r <= (begin_wr || cont_wr) && any_lane; // [RQ5] [RQ9]
      wr_addr_r <= acc_addr;
      wr_strb_n_r <= bus.byte_lane_strobe_n;
    end
  end

  // data of a write is taken on the next live edge
  always_ff @(posedge clk) begin
    if (live && wr_pend_r) begin
      for (int i = 0; i < LANES; i++) begin
        if (!wr_strb_n_r[i]) begin
          mem[wr_addr_r][i*LANE_W +: LANE_W] <= bus.dq[i*LANE_W +: LANE_W]; // [RQ9]
        end
      end
    end
  end

  // ****************************************
  // sleep entry and exit
  // ****************************************
  // request must persist for the full count, glitches restart it
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      asleep_r <= 1'b0;
      zz_cnt_r <= '0;
    end else if (bus.sleep_request != asleep_r) begin
      if (asleep_r && (zz_cnt_r == CW'(SSP_SLEEP_EXIT_CYC - 1))) begin
        asleep_r <= 1'b0; // [RQ13]
        zz_cnt_r <= '0;
      end else if (!asleep_r && (zz_cnt_r == CW'(SSP_SLEEP_ENTER_CYC - 1))) begin
        asleep_r <= 1'b1; // [RQ13]
        zz_cnt_r <= '0;
      end else begin
        zz_cnt_r <= CW'(zz_cnt_r + 1'b1);
      end
    end else begin
      zz_cnt_r <= '0;
    end
  end

  assign sleeping = asleep_r;
  assign deselected = (state_r == SSP_DESEL);

endmodule
